// *** data_memory_map_pkg.sv ***
// Shared constants and types for the data memory address map block
package data_memory_map_pkg;

  // ----------------------------------------
  // Memory sizes
  // ----------------------------------------
  localparam int IRAM_BYTES = 256;
  localparam int IRAM_AW = 8;
  localparam int EXPANDED_RAM_BYTES = 768;
  localparam int EXPANDED_RAM_AW = 10;
  localparam logic [16:0] CODE_LIMIT = 17'h04000;
  localparam logic [15:0] EXPANDED_RAM_LAST = 16'h02FF;

  // ----------------------------------------
  // Internal address map
  // ----------------------------------------
  localparam logic [7:0] DIRECT_LIMIT = 8'h7F;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] INDEX_REG_MASK = 8'h01;

  // ----------------------------------------
  // Local special function registers
  // ----------------------------------------
  localparam logic [7:0] SFR_POINTER_LOW = 8'h82;
  localparam logic [7:0] SFR_POINTER_HIGH = 8'h83;
  localparam logic [7:0] SFR_PAGE_SELECT = 8'h8F;
  localparam logic [7:0] SFR_AUX_CONTROL_ONE = 8'hA2;
  localparam int AUX_POINTER_SELECT_BIT = 0;
  localparam int AUX_CRC_SOURCE_LSB = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam logic [1:0] PAGE_RESET = 2'h0;
  localparam logic [1:0] CRC_SOURCE_RESET = 2'h0;
  localparam logic POINTER_SELECT_RESET = 1'b0;

  // ----------------------------------------
  // Request kinds from the core, decode targets and FSM states
  // ----------------------------------------
  typedef enum logic [2:0] {
    KIND_DIRECT,
    KIND_INDIRECT,
    KIND_REGISTER,
    KIND_BIT,
    KIND_XMOVE_PAGED,
    KIND_XMOVE_POINTER,
    KIND_POINTER_INC,
    KIND_POINTER_LOAD
  } access_kind_type;

  typedef enum logic [2:0] {
    TGT_IRAM,
    TGT_SFR_LOCAL,
    TGT_SFR_EXT,
    TGT_EXPANDED_RAM,
    TGT_NONE
  } target_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INDEX_READ,
    ST_INDEX_WAIT,
    ST_READ,
    ST_WAIT,
    ST_WRITE,
    ST_RESPOND
  } fsm_state_type;

endpackage : data_memory_map_pkg

// *** ram_port_if.sv ***
// Byte memory port between the map logic and its storage arrays
`timescale 1ns/100ps

interface ram_port_if #(parameter int AW = 8);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport core (output en, output we, output addr, output wdata, input rdata);
  modport memory (input en, input we, input addr, input wdata, output rdata);
endinterface : ram_port_if

// *** byte_ram.sv ***
// Single-port byte RAM with one-cycle synchronous read
`timescale 1ns/100ps

module byte_ram
#(
  parameter int DEPTH = 256,
  parameter int AW = 8
)
(
  // Clock
  input wire logic i_ref_clk,
  // Memory port
  ram_port_if.memory port
);

  logic [7:0] mem_array [DEPTH];
  logic [7:0] rdata_ff;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Read data holds until the next enabled read
  always_ff @(posedge i_ref_clk)
  begin
    if (port.en)
    begin
      if (port.we)
        mem_array[port.addr] <= port.wdata;
      else
        rdata_ff <= mem_array[port.addr];
    end
  end

  assign port.rdata = rdata_ff;

endmodule : byte_ram

// *** data_memory_map.sv ***
// Data memory decoder: internal RAM, local SFRs, expanded RAM
`timescale 1ns/100ps

// Summary of operation
// R01: Internal addresses are 8 bits, 256 bytes
// R02: Direct above 7FH goes to SFR space
// R03: Indirect above 7FH reaches separate upper RAM
// R04: Low 32 bytes are four register banks
// R05: Bytes 20H-2FH hold bit addresses 00H-7FH
// R06: Lower 128 direct or indirect; upper indirect
// R07: SFRs answer direct addressing only
// R08: SFRs ending 0H or 8H are bit-addressable
// R09: 768 bytes expanded RAM, 0000H-02FFH
// R10: External moves never leave the chip
// R11: Paged move address is page then R0/R1
// R12: Pointer move uses selected pointer as address
// R13: Two pointers, select bit picks one
// R14: Pointer instructions act on selected pointer
// R15: Increment adds one over all 16 bits
// R16: Paged window shares expanded RAM storage
// R17: 16K program space read through pointer index
// R18: Aux control one at A2H, bits 5:4,0
// R19: Pointer low byte at 82H, reset zero
// R20: Pointer high byte at 83H, reset zero
// R21: Page select at 8FH, low bits reset 00
// R22: Page select low two bits, upper read zero
// R23: Bank select bits pick Rn bank
// R24: Unimplemented expanded addresses: write ignored, read 0
module data_memory_map
  import data_memory_map_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Core request
  input wire logic i_req_valid,
  input wire access_kind_type i_req_kind,
  input wire logic i_req_write,
  input wire logic [7:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  input wire logic [15:0] i_req_imm,
  output logic o_req_ready,
  // Core response
  output logic o_resp_valid,
  output logic [7:0] o_rdata,
  // Core state used for decoding
  input wire logic [1:0] i_bank_select,
  input wire logic [7:0] i_acc,
  // Other special function registers
  output logic o_sfr_rd,
  output logic o_sfr_wr,
  output logic [7:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata,
  input wire logic [7:0] i_sfr_rdata,
  // Pointer and control outputs
  output logic o_pointer_select,
  output logic [1:0] o_crc_source_select,
  output logic [15:0] o_data_pointer,
  output logic [15:0] o_code_addr,
  output logic o_code_in_range
);

  typedef struct packed {
    fsm_state_type st;
    access_kind_type kind;
    logic write;
    logic [2:0] bit_idx;
    logic [7:0] byte_addr;
    target_type tgt;
    logic [15:0] eaddr;
    logic [7:0] wdata;
    logic [7:0] hold;
    logic [7:0] rdata;
    logic [15:0] pointer_zero;
    logic [15:0] pointer_one;
    logic pointer_select;
    logic [1:0] crc_source;
    logic [1:0] page;
  } map_state_type;

  localparam map_state_type RESET_STATE = '{
    st: ST_IDLE,
    kind: KIND_DIRECT,
    write: 1'b0,
    bit_idx: 3'h0,
    byte_addr: 8'h00,
    tgt: TGT_IRAM,
    eaddr: 16'h0000,
    wdata: 8'h00,
    hold: 8'h00,
    rdata: 8'h00,
    pointer_zero: POINTER_RESET,
    pointer_one: POINTER_RESET,
    pointer_select: POINTER_SELECT_RESET,
    crc_source: CRC_SOURCE_RESET,
    page: PAGE_RESET
  };

  map_state_type map_ff;
  map_state_type nxt_map;

  ram_port_if #(.AW(IRAM_AW)) iram_port ();
  ram_port_if #(.AW(EXPANDED_RAM_AW)) expanded_ram_port ();

  // ----------------------------------------
  // Storage arrays
  // ----------------------------------------
  // Lower and upper 128 share one array; SFRs live elsewhere
  byte_ram #(.DEPTH(IRAM_BYTES), .AW(IRAM_AW)) iram_store
  (
    .i_ref_clk(i_ref_clk),
    .port(iram_port.memory)
  ); // [R01] [R03]

  // Both external-move forms land here; no off-chip path exists
  byte_ram #(.DEPTH(EXPANDED_RAM_BYTES), .AW(EXPANDED_RAM_AW)) expanded_ram_store
  (
    .i_ref_clk(i_ref_clk),
    .port(expanded_ram_port.memory)
  ); // [R09] [R10] [R16]

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] selected_pointer(input map_state_type s);
    selected_pointer = s.pointer_select ? s.pointer_one : s.pointer_zero;
  endfunction : selected_pointer

  function automatic target_type sfr_target(input logic [7:0] addr);
    if (addr == SFR_POINTER_LOW || addr == SFR_POINTER_HIGH ||
        addr == SFR_PAGE_SELECT || addr == SFR_AUX_CONTROL_ONE)
      sfr_target = TGT_SFR_LOCAL;
    else
      sfr_target = TGT_SFR_EXT;
  endfunction : sfr_target

  function automatic target_type expanded_ram_target(input logic [15:0] addr);
    expanded_ram_target = (addr <= EXPANDED_RAM_LAST) ? TGT_EXPANDED_RAM : TGT_NONE; // [R24]
  endfunction : expanded_ram_target

  function automatic logic [7:0] local_read(input map_state_type s);
    logic [15:0] ptr;
    ptr = selected_pointer(s);
    local_read = 8'h00;
    unique case (s.byte_addr)
      SFR_POINTER_LOW: local_read = ptr[7:0]; // [R19]
      SFR_POINTER_HIGH: local_read = ptr[15:8]; // [R20]
      SFR_PAGE_SELECT: local_read = {6'h00, s.page}; // [R22]
      SFR_AUX_CONTROL_ONE:
      begin
        local_read[AUX_CRC_SOURCE_LSB +: 2] = s.crc_source; // [R18]
        local_read[AUX_POINTER_SELECT_BIT] = s.pointer_select;
      end
      default: local_read = 8'h00;
    endcase
  endfunction : local_read

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] byte_v;
    logic [7:0] merged;
    logic [15:0] ptr;
    byte_v = 8'h00;
    merged = 8'h00;
    ptr = selected_pointer(map_ff);
    nxt_map = map_ff;
    iram_port.en = 1'b0;
    iram_port.we = 1'b0;
    iram_port.addr = map_ff.byte_addr;
    iram_port.wdata = map_ff.wdata;
    expanded_ram_port.en = 1'b0;
    expanded_ram_port.we = 1'b0;
    expanded_ram_port.addr = map_ff.eaddr[EXPANDED_RAM_AW-1:0];
    expanded_ram_port.wdata = map_ff.wdata;
    o_sfr_rd = 1'b0;
    o_sfr_wr = 1'b0;
    unique case (map_ff.st)
      ST_IDLE:
      begin
        if (i_req_valid)
        begin
          nxt_map.kind = i_req_kind;
          nxt_map.write = i_req_write;
          nxt_map.wdata = i_req_wdata;
          nxt_map.bit_idx = i_req_addr[2:0];
          nxt_map.byte_addr = i_req_addr;
          nxt_map.tgt = TGT_IRAM;
          nxt_map.st = i_req_write ? ST_WRITE : ST_READ;
          unique case (i_req_kind)
            KIND_DIRECT:
            begin
              // Above 7FH direct means SFR, never upper RAM
              if (i_req_addr > DIRECT_LIMIT)
                nxt_map.tgt = sfr_target(i_req_addr); // [R02] [R06] [R07]
            end
            KIND_INDIRECT:
            begin
              // Whole 256 bytes are RAM; SFRs cannot be reached here
              nxt_map.tgt = TGT_IRAM; // [R03] [R06] [R07]
            end
            KIND_REGISTER:
            begin
              nxt_map.byte_addr = {3'h0, i_bank_select, i_req_addr[2:0]}; // [R04] [R23]
            end
            KIND_BIT:
            begin
              // Bit writes need a read first, so always start by reading
              nxt_map.st = ST_READ;
              if (i_req_addr > DIRECT_LIMIT)
              begin
                nxt_map.byte_addr = {i_req_addr[7:3], 3'h0}; // [R08]
                nxt_map.tgt = sfr_target({i_req_addr[7:3], 3'h0});
              end
              else
              begin
                nxt_map.byte_addr = BIT_AREA_BASE + {4'h0, i_req_addr[6:3]}; // [R05]
              end
            end
            KIND_XMOVE_PAGED:
            begin
              nxt_map.byte_addr =
                {3'h0, i_bank_select, 3'h0} | (i_req_addr & INDEX_REG_MASK); // [R11]
              nxt_map.st = ST_INDEX_READ;
            end
            KIND_XMOVE_POINTER:
            begin
              nxt_map.eaddr = ptr; // [R12] [R14]
              nxt_map.tgt = expanded_ram_target(ptr);
            end
            KIND_POINTER_INC:
            begin
              // Wraps from FFFFH to 0000H
              if (map_ff.pointer_select)
                nxt_map.pointer_one = map_ff.pointer_one + 16'h0001; // [R15] [R14]
              else
                nxt_map.pointer_zero = map_ff.pointer_zero + 16'h0001; // [R15]
              nxt_map.st = ST_RESPOND;
            end
            KIND_POINTER_LOAD:
            begin
              if (map_ff.pointer_select)
                nxt_map.pointer_one = i_req_imm; // [R13] [R14]
              else
                nxt_map.pointer_zero = i_req_imm; // [R13]
              nxt_map.st = ST_RESPOND;
            end
            default: nxt_map.st = ST_RESPOND;
          endcase
        end
      end
      ST_INDEX_READ:
      begin
        iram_port.en = 1'b1;
        nxt_map.st = ST_INDEX_WAIT;
      end
      ST_INDEX_WAIT:
      begin
        // Upper bits of the page register are always zero
        nxt_map.eaddr = {6'h00, map_ff.page, iram_port.rdata}; // [R11] [R16] [R22]
        nxt_map.tgt = expanded_ram_target({6'h00, map_ff.page, iram_port.rdata}); // [R24]
        nxt_map.st = map_ff.write ? ST_WRITE : ST_READ;
      end
      ST_READ:
      begin
        unique case (map_ff.tgt)
          TGT_IRAM: iram_port.en = 1'b1;
          TGT_EXPANDED_RAM: expanded_ram_port.en = 1'b1;
          TGT_SFR_LOCAL: nxt_map.hold = local_read(map_ff);
          TGT_SFR_EXT:
          begin
            o_sfr_rd = 1'b1;
            nxt_map.hold = i_sfr_rdata;
          end
          default: nxt_map.hold = 8'h00; // [R24]
        endcase
        nxt_map.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        unique case (map_ff.tgt)
          TGT_IRAM: byte_v = iram_port.rdata;
          TGT_EXPANDED_RAM: byte_v = expanded_ram_port.rdata;
          default: byte_v = map_ff.hold;
        endcase
        if (map_ff.kind == KIND_BIT)
        begin
          nxt_map.rdata = {7'h00, byte_v[map_ff.bit_idx]}; // [R05] [R08]
          merged = byte_v;
          merged[map_ff.bit_idx] = map_ff.wdata[0];
          nxt_map.wdata = merged;
          nxt_map.st = map_ff.write ? ST_WRITE : ST_RESPOND;
        end
        else
        begin
          nxt_map.rdata = byte_v;
          nxt_map.st = ST_RESPOND;
        end
      end
      ST_WRITE:
      begin
        unique case (map_ff.tgt)
          TGT_IRAM:
          begin
            iram_port.en = 1'b1;
            iram_port.we = 1'b1;
          end
          TGT_EXPANDED_RAM:
          begin
            expanded_ram_port.en = 1'b1;
            expanded_ram_port.we = 1'b1;
          end
          TGT_SFR_EXT: o_sfr_wr = 1'b1;
          TGT_SFR_LOCAL:
          begin
            unique case (map_ff.byte_addr)
              SFR_POINTER_LOW:
              begin
                if (map_ff.pointer_select)
                  nxt_map.pointer_one[7:0] = map_ff.wdata; // [R19]
                else
                  nxt_map.pointer_zero[7:0] = map_ff.wdata;
              end
              SFR_POINTER_HIGH:
              begin
                if (map_ff.pointer_select)
                  nxt_map.pointer_one[15:8] = map_ff.wdata; // [R20]
                else
                  nxt_map.pointer_zero[15:8] = map_ff.wdata;
              end
              SFR_PAGE_SELECT:
                nxt_map.page = map_ff.wdata[1:0]; // [R21] [R22]
              SFR_AUX_CONTROL_ONE:
              begin
                nxt_map.crc_source = map_ff.wdata[AUX_CRC_SOURCE_LSB +: 2]; // [R18]
                nxt_map.pointer_select = map_ff.wdata[AUX_POINTER_SELECT_BIT]; // [R13]
              end
              default: nxt_map.page = map_ff.page;
            endcase
          end
          default: nxt_map.st = ST_RESPOND; // [R24]
        endcase
        nxt_map.st = ST_RESPOND;
      end
      ST_RESPOND:
      begin
        nxt_map.st = ST_IDLE;
      end
      default: nxt_map.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      map_ff <= RESET_STATE; // [R18] [R19] [R20] [R21]
    else
      map_ff <= nxt_map;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_req_ready = (map_ff.st == ST_IDLE);
  assign o_resp_valid = (map_ff.st == ST_RESPOND);
  assign o_rdata = map_ff.rdata;
  assign o_sfr_addr = map_ff.byte_addr;
  assign o_sfr_wdata = map_ff.wdata;
  assign o_pointer_select = map_ff.pointer_select;
  assign o_crc_source_select = map_ff.crc_source;
  assign o_data_pointer = selected_pointer(map_ff); // [R14]
  // Table reads and indirect jumps index from the selected pointer
  assign o_code_addr = selected_pointer(map_ff) + {8'h00, i_acc}; // [R17] [R14]
  assign o_code_in_range = ({1'b0, o_code_addr} < CODE_LIMIT); // [R17]

endmodule : data_memory_map

// *** data_memory_map_props.sv ***
// Concurrent checks on the ports of the data memory map block
`timescale 1ns/100ps

module data_memory_map_props
  import data_memory_map_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Core request and response
  input wire logic i_req_valid,
  input wire access_kind_type i_req_kind,
  input wire logic i_req_write,
  input wire logic [7:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  input wire logic [15:0] i_req_imm,
  input wire logic o_req_ready,
  input wire logic o_resp_valid,
  input wire logic [7:0] i_acc,
  // Outside SFR bus
  input wire logic o_sfr_rd,
  input wire logic o_sfr_wr,
  input wire logic [7:0] o_sfr_addr,
  input wire logic [7:0] o_sfr_wdata,
  // Pointer outputs
  input wire logic o_pointer_select,
  input wire logic [15:0] o_data_pointer,
  input wire logic [15:0] o_code_addr,
  input wire logic o_code_in_range
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic take = i_req_valid && o_req_ready;
  wire logic direct = take && i_req_kind == KIND_DIRECT;
  // Local SFRs never reach the outside bus
  wire logic far_sfr = i_req_addr > DIRECT_LIMIT && !(i_req_addr inside
    {SFR_POINTER_LOW, SFR_POINTER_HIGH, SFR_PAGE_SELECT,
     SFR_AUX_CONTROL_ONE});

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_direct_sfr_read: assert property (direct && !i_req_write && far_sfr
    |=> o_sfr_rd && o_sfr_addr == $past(i_req_addr))
    else $error("direct read missed the SFR bus");
  a_direct_sfr_write: assert property (direct && i_req_write && far_sfr
    |=> o_sfr_wr && o_sfr_wdata == $past(i_req_wdata))
    else $error("direct write missed the SFR bus");
  a_indirect_no_sfr: assert property (take && i_req_kind == KIND_INDIRECT
    |=> (!o_sfr_rd && !o_sfr_wr) [*3])
    else $error("indirect access touched SFR bus");
  a_xmove_stays_local: assert property (take && i_req_kind inside
    {KIND_XMOVE_PAGED, KIND_XMOVE_POINTER} |=> (!o_sfr_rd && !o_sfr_wr) [*5])
    else $error("external move left the chip");
  a_load_pointer: assert property (take && i_req_kind == KIND_POINTER_LOAD
    |=> o_resp_valid && o_data_pointer == $past(i_req_imm))
    else $error("pointer load wrong");
  a_inc_pointer: assert property (take && i_req_kind == KIND_POINTER_INC
    |=> o_data_pointer == $past(o_data_pointer) + 16'h0001)
    else $error("pointer increment wrong");
  a_code_index: assert property (o_code_addr == o_data_pointer +
    {8'h00, i_acc} && o_code_in_range == (o_code_addr < 16'h4000))
    else $error("code index address wrong");
  a_select_write: assert property (direct && i_req_write &&
    i_req_addr == SFR_AUX_CONTROL_ONE
    |-> ##2 o_pointer_select == $past(i_req_wdata[0], 2))
    else $error("pointer select not written");
  a_reset_clean: assert property ($fell(i_sys_rst) |->
    o_data_pointer == POINTER_RESET && !o_pointer_select && o_req_ready)
    else $error("reset values wrong");
endmodule : data_memory_map_props

bind data_memory_map data_memory_map_props u_data_memory_map_props (
  .i_ref_clk, .i_sys_rst, .i_req_valid, .i_req_kind, .i_req_write,
  .i_req_addr, .i_req_wdata, .i_req_imm, .o_req_ready, .o_resp_valid,
  .i_acc, .o_sfr_rd, .o_sfr_wr, .o_sfr_addr, .o_sfr_wdata,
  .o_pointer_select, .o_data_pointer, .o_code_addr, .o_code_in_range
);

// *** sfr_bus_model.sv ***
// Model of the outside special function registers on the SFR bus
`timescale 1ns/100ps

module sfr_bus_model
(
  // Clock
  input wire logic i_ref_clk,
  // Bus from the map block
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] regs_ff [0:255] = '{default: 8'h00};

  // Off a read strobe the bus shows no stale byte
  assign o_rdata = i_rd ? regs_ff[i_addr] : ~regs_ff[i_addr];

  always @(posedge i_ref_clk)
    if (i_wr)
      regs_ff[i_addr] <= i_wdata;
endmodule : sfr_bus_model

// *** testbench.sv ***
// Self-checking bench for the data memory map block
`timescale 1ns/100ps

module testbench
  import data_memory_map_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic i_ref_clk, i_sys_rst, i_req_valid, i_req_write;
  access_kind_type i_req_kind;
  logic [7:0] i_req_addr, i_req_wdata, i_acc, i_sfr_rdata, seen;
  logic [15:0] i_req_imm;
  logic [1:0] i_bank_select;
  logic o_req_ready, o_resp_valid, o_sfr_rd, o_sfr_wr, o_pointer_select;
  logic o_code_in_range;
  logic [7:0] o_rdata, o_sfr_addr, o_sfr_wdata;
  logic [1:0] o_crc_source_select;
  logic [15:0] o_data_pointer, o_code_addr;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  // Reads compare v[7:0]; addr[4:3] doubles as the bank select
  typedef struct {access_kind_type k; logic w; logic [7:0] a;
    logic [15:0] v;} row_type;
  row_type rows [44] = '{
    '{KIND_DIRECT, 1'h1, 8'h10, 16'h005A},
    '{KIND_INDIRECT, 1'h0, 8'h10, 16'h005A},
    '{KIND_INDIRECT, 1'h1, 8'h90, 16'h00C3},
    '{KIND_DIRECT, 1'h1, 8'h90, 16'h0011},
    '{KIND_INDIRECT, 1'h0, 8'h90, 16'h00C3},
    '{KIND_DIRECT, 1'h0, 8'h90, 16'h0011},
    '{KIND_REGISTER, 1'h1, 8'h11, 16'h003C},
    '{KIND_DIRECT, 1'h0, 8'h11, 16'h003C},
    '{KIND_DIRECT, 1'h1, 8'h21, 16'h0000},
    '{KIND_BIT, 1'h1, 8'h0A, 16'h0001},
    '{KIND_DIRECT, 1'h0, 8'h21, 16'h0004},
    '{KIND_BIT, 1'h0, 8'h0A, 16'h0001},
    '{KIND_BIT, 1'h1, 8'h93, 16'h0001},
    '{KIND_DIRECT, 1'h0, 8'h90, 16'h0019},
    '{KIND_XMOVE_POINTER, 1'h1, 8'h00, 16'h0000},
    '{KIND_DIRECT, 1'h1, 8'hA2, 16'h00FF},
    '{KIND_DIRECT, 1'h0, 8'hA2, 16'h0031},
    '{KIND_POINTER_LOAD, 1'h1, 8'h00, 16'h0123},
    '{KIND_DIRECT, 1'h0, 8'h82, 16'h0023},
    '{KIND_DIRECT, 1'h0, 8'h83, 16'h0001},
    '{KIND_XMOVE_POINTER, 1'h1, 8'h00, 16'h0077},
    '{KIND_DIRECT, 1'h1, 8'h8F, 16'h0001},
    '{KIND_DIRECT, 1'h0, 8'h8F, 16'h0001},
    '{KIND_REGISTER, 1'h1, 8'h00, 16'h0023},
    '{KIND_XMOVE_PAGED, 1'h0, 8'h00, 16'h0077},
    '{KIND_DIRECT, 1'h1, 8'hA2, 16'h0000},
    '{KIND_DIRECT, 1'h0, 8'h82, 16'h0000},
    '{KIND_POINTER_LOAD, 1'h1, 8'h00, 16'h02FF},
    '{KIND_XMOVE_POINTER, 1'h1, 8'h00, 16'h005E},
    '{KIND_XMOVE_POINTER, 1'h0, 8'h00, 16'h005E},
    '{KIND_POINTER_INC, 1'h1, 8'h00, 16'h0000},
    '{KIND_DIRECT, 1'h0, 8'h83, 16'h0003},
    '{KIND_XMOVE_POINTER, 1'h1, 8'h00, 16'h00AA},
    '{KIND_XMOVE_POINTER, 1'h0, 8'h00, 16'h0000},
    '{KIND_POINTER_LOAD, 1'h1, 8'h00, 16'h0000},
    '{KIND_XMOVE_POINTER, 1'h0, 8'h00, 16'h0000},
    '{KIND_POINTER_LOAD, 1'h1, 8'h00, 16'hFFFF},
    '{KIND_POINTER_INC, 1'h1, 8'h00, 16'h0000},
    '{KIND_DIRECT, 1'h0, 8'h83, 16'h0000},
    '{KIND_DIRECT, 1'h0, 8'h82, 16'h0000},
    '{KIND_REGISTER, 1'h1, 8'h01, 16'h00FF},
    '{KIND_XMOVE_PAGED, 1'h1, 8'h01, 16'h0042},
    '{KIND_POINTER_LOAD, 1'h1, 8'h00, 16'h01FF},
    '{KIND_XMOVE_POINTER, 1'h0, 8'h00, 16'h0042}
  };

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  data_memory_map u_data_memory_map (.*);
  sfr_bus_model u_sfr_bus_model (.i_ref_clk(i_ref_clk), .i_rd(o_sfr_rd),
    .i_wr(o_sfr_wr), .i_addr(o_sfr_addr), .i_wdata(o_sfr_wdata),
    .o_rdata(i_sfr_rdata));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_value

  task automatic run_req(input access_kind_type k, input logic w,
    input logic [7:0] a, input logic [15:0] v);
    int n;
    i_req_valid <= 1'h1;
    i_req_kind <= k;
    i_req_write <= w;
    i_req_addr <= a;
    i_req_wdata <= v[7:0];
    i_req_imm <= v;
    i_bank_select <= a[4:3];
    i_acc <= v[15:8];
    @(posedge i_ref_clk);
    i_req_valid <= 1'h0;
    n = 0;
    // Bounded wait: a lost response must not hang the run
    do
    begin
      @(posedge i_ref_clk);
      n++;
    end
    while (o_resp_valid !== 1'h1 && n < 20);
    seen = o_rdata;
    check_value({15'h0000, o_resp_valid}, 16'h0001);
  endtask : run_req

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Clock and timeout
  // ----------------------------------------
  initial
  begin
    i_ref_clk = 1'h0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    i_sys_rst = 1'h1;
    i_req_valid = 1'h0;
    i_req_kind = KIND_DIRECT;
    i_req_write = 1'h0;
    i_req_addr = 8'h00;
    i_req_wdata = 8'h00;
    i_req_imm = 16'h0000;
    i_bank_select = 2'h0;
    i_acc = 8'h00;
    repeat (12) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    @(posedge i_ref_clk);
    foreach (rows[n])
    begin
      run_req(rows[n].k, rows[n].w, rows[n].a, rows[n].v);
      if (!rows[n].w)
        check_value({8'h00, seen}, {8'h00, rows[n].v[7:0]});
    end
    run_req(KIND_DIRECT, 1'h1, SFR_AUX_CONTROL_ONE, 16'h0021);
    check_value({14'h0000, o_crc_source_select}, 16'h0002);
    check_value(o_data_pointer, 16'h0123);
    run_req(KIND_POINTER_LOAD, 1'h1, 8'h00, 16'hA55A);
    // Reset in mid-run must clear both pointers and the controls
    i_sys_rst <= 1'h1;
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    @(posedge i_ref_clk);
    check_value({14'h0000, o_crc_source_select}, 16'h0000);
    check_value(o_data_pointer, 16'h0000);
    run_req(KIND_DIRECT, 1'h0, SFR_PAGE_SELECT, 16'h0000);
    check_value({8'h00, seen}, 16'h0000);
    run_req(KIND_DIRECT, 1'h1, SFR_AUX_CONTROL_ONE, 16'h0001);
    run_req(KIND_DIRECT, 1'h0, SFR_POINTER_HIGH, 16'h0000);
    check_value({8'h00, seen}, 16'h0000);
    // Table index past 16K must drop out of range
    run_req(KIND_POINTER_LOAD, 1'h1, 8'h00, 16'h3FF0);
    check_value(o_code_addr, 16'h402F);
    check_value({15'h0000, o_code_in_range}, 16'h0000);
    run_req(KIND_POINTER_LOAD, 1'h1, 8'h00, 16'h2010);
    check_value(o_code_addr, 16'h2030);
    check_value({15'h0000, o_code_in_range}, 16'h0001);
    check_value({15'h0000, o_pointer_select}, 16'h0001);
    // Indirect 82H is upper RAM, never the pointer low byte
    run_req(KIND_INDIRECT, 1'h1, SFR_POINTER_LOW, 16'h005C);
    run_req(KIND_INDIRECT, 1'h0, SFR_POINTER_LOW, 16'h0000);
    check_value({8'h00, seen}, 16'h005C);
    check_value(o_data_pointer, 16'h2010);
    complete_run();
  end
endmodule : testbench
